// file: hdl/pcsc_client_port.sv
// PCS client port: byte and nibble transmit/receive towards a MAC,
// collision and carrier sense, and speed/duplex status from APB control or partner ability.
// Assumes the line side and the MAC are logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module pcsc_client_port
    import pcsc_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // MAC transmit
    input  wire logic [7:0]  gig_tx_data,
    input  wire logic        gig_tx_en,
    input  wire logic        gig_tx_err,
    input  wire logic [3:0]  nib_tx_data,
    input  wire logic        nib_tx_en,
    input  wire logic        nib_tx_err,
    // MAC receive
    output logic [7:0]       gig_rx_data,
    output logic             gig_rx_valid,
    output logic             gig_rx_err,
    output logic [3:0]       nib_rx_data,
    output logic             nib_rx_valid,
    output logic             nib_rx_err,
    output logic             nib_col,
    output logic             nib_crs,
    // Status and enables
    output logic             set_1000,
    output logic             set_100,
    output logic             set_10,
    output logic             half_duplex_active,
    output logic             tx_clk_ena,
    output logic             rx_clk_ena,
    // Line side
    output logic [7:0]       line_tx_data,
    output logic             line_tx_valid,
    output logic             line_tx_err,
    input  wire logic [7:0]  line_rx_data,
    input  wire logic        line_rx_valid,
    input  wire logic        line_rx_err,
    output logic             line_rx_ready,
    input  wire logic        line_rx_active,
    input  wire logic        line_collision,
    input  wire logic [15:0] partner_ability,
    input  wire logic        partner_ability_new
);

    // ========================================================
    // Registers and clock enables
    // ========================================================
    logic [PCSC_CTRL_W-1:0] ctrl_reg;
    logic [PCSC_AB_W-1:0]   ability_reg;
    logic [31:0]            rdata_reg;
    logic                   err_reg;
    logic                   tx_active_reg, nib_hi_reg;
    logic                   sgmii, an_on, nib_mode, tick;
    logic [1:0]             man_spd;
    pcsc_rate_t             rate;
    pcsc_clken_if           ce ();

    assign sgmii   = ctrl_reg[PCSC_CTRL_SGMII];
    assign an_on   = sgmii && ctrl_reg[PCSC_CTRL_AN];
    assign man_spd = ctrl_reg[PCSC_CTRL_SPD_LSB +: 2];

    pcsc_clken_gen u_clken (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce.gen)
    );

    assign ce.rate = rate;
    assign tick    = ce.tick;
    assign nib_mode = sgmii && (set_100 || set_10);

    assign tx_clk_ena = sgmii && tick;
    assign rx_clk_ena = sgmii && tick;

    // ========================================================
    // APB slave: zero wait, read data captured in setup
    // ========================================================
    function automatic logic addr_ok(logic [11:0] a, logic wr);
        addr_ok = (a == PCSC_ADDR_CTRL) ||
                  (!wr && (a == PCSC_ADDR_STATUS || a == PCSC_ADDR_ABILITY));
    endfunction

    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign pslverr = psel && penable && err_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end
        else if (psel && !penable)
        begin
            err_reg <= !addr_ok(paddr, pwrite);
            unique case (paddr)
                PCSC_ADDR_CTRL:
                    rdata_reg <= 32'(ctrl_reg);
                PCSC_ADDR_STATUS:
                    rdata_reg <= 32'({line_rx_active, tx_active_reg,
                        half_duplex_active, set_10, set_100, set_1000});
                PCSC_ADDR_ABILITY:
                    rdata_reg <= 32'(ability_reg);
                default:
                    rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= PCSC_CTRL_RESET;
        else if (psel && penable && pwrite && paddr == PCSC_ADDR_CTRL)
            ctrl_reg <= pwdata[PCSC_CTRL_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ability_reg <= PCSC_AB_RESET;
        else if (partner_ability_new)
            ability_reg <= partner_ability;
    end

    // ========================================================
    // Speed and duplex status
    // ========================================================
    logic [1:0] ab_spd;
    assign ab_spd = ability_reg[PCSC_AB_SPD_LSB +: 2];

    always_comb
    begin
        if (!sgmii)
            rate = PCSC_RATE_1000;
        else if (an_on && !ability_reg[PCSC_AB_LINK])
            rate = PCSC_RATE_OFF;
        else
        begin
            unique case (an_on ? ab_spd : man_spd)
                PCSC_SPD_1000: rate = PCSC_RATE_1000;
                PCSC_SPD_100:  rate = PCSC_RATE_100;
                PCSC_SPD_10:   rate = PCSC_RATE_10;
                default:       rate = PCSC_RATE_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            set_1000 <= 1'b0;
            set_100  <= 1'b0;
            set_10   <= 1'b0;
        end
        else
        begin
            set_1000 <= (rate == PCSC_RATE_1000);
            set_100  <= (rate == PCSC_RATE_100);
            set_10   <= (rate == PCSC_RATE_10);
        end
    end

    // Half duplex from ability or bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_duplex_active <= 1'b0;
        else if (!sgmii)
            half_duplex_active <= 1'b0;
        else if (an_on)
            half_duplex_active <= ability_reg[PCSC_AB_LINK] &&
                                  !ability_reg[PCSC_AB_DUPLEX];
        else
            half_duplex_active <= ctrl_reg[PCSC_CTRL_DUPLEX];
    end

    // ========================================================
    // Transmit: bytes pass, nibbles pair low first
    // ========================================================
    logic [3:0] nib_lo_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_tx_data  <= 8'h00;
            line_tx_valid <= 1'b0;
            line_tx_err   <= 1'b0;
            tx_active_reg <= 1'b0;
            nib_hi_reg    <= 1'b0;
            nib_lo_reg    <= 4'h0;
        end
        else
        begin
            line_tx_valid <= 1'b0;
            if (tick && !nib_mode)
            begin
                tx_active_reg <= gig_tx_en;
                line_tx_valid <= gig_tx_en;
                line_tx_data  <= gig_tx_data;
                line_tx_err   <= gig_tx_en && gig_tx_err;
            end
            else if (tick)
            begin
                tx_active_reg <= nib_tx_en;
                if (!nib_tx_en)
                    nib_hi_reg <= 1'b0;
                else if (!nib_hi_reg)
                begin
                    nib_hi_reg <= 1'b1;
                    nib_lo_reg <= nib_tx_data;
                    line_tx_err <= nib_tx_err;
                end
                else
                begin
                    nib_hi_reg    <= 1'b0;
                    line_tx_valid <= 1'b1;
                    line_tx_data  <= {nib_tx_data, nib_lo_reg};
                    line_tx_err   <= line_tx_err || nib_tx_err;
                end
            end
        end
    end

    // ========================================================
    // Receive: one byte held, sent whole or as two nibbles
    // ========================================================
    logic [7:0] rx_hold_reg;
    logic       rx_full_reg, rx_err_reg, rx_half_reg;

    assign line_rx_ready = !rx_full_reg;

    // Valid and error follow held byte.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_hold_reg  <= 8'h00;
            rx_full_reg  <= 1'b0;
            rx_err_reg   <= 1'b0;
            rx_half_reg  <= 1'b0;
            gig_rx_data  <= 8'h00;
            gig_rx_valid <= 1'b0;
            gig_rx_err   <= 1'b0;
            nib_rx_data  <= 4'h0;
            nib_rx_valid <= 1'b0;
            nib_rx_err   <= 1'b0;
        end
        else
        begin
            if (line_rx_valid && !rx_full_reg)
            begin
                rx_hold_reg <= line_rx_data;
                rx_err_reg  <= line_rx_err;
                rx_full_reg <= 1'b1;
            end
            if (tick && !nib_mode)
            begin
                gig_rx_valid <= rx_full_reg;
                gig_rx_data  <= rx_full_reg ? rx_hold_reg : 8'h00;
                gig_rx_err   <= rx_full_reg && rx_err_reg;
                nib_rx_valid <= 1'b0;
                nib_rx_err   <= 1'b0;
                // Only a byte already held is released, so a byte taken
                // on this same edge is kept.
                if (rx_full_reg)
                    rx_full_reg <= 1'b0;
            end
            else if (tick)
            begin
                gig_rx_valid <= 1'b0;
                gig_rx_err   <= 1'b0;
                nib_rx_valid <= rx_full_reg;
                nib_rx_err   <= rx_full_reg && rx_err_reg;
                nib_rx_data  <= rx_half_reg ? rx_hold_reg[7:4]
                                            : rx_hold_reg[3:0];
                if (rx_full_reg)
                    rx_half_reg <= !rx_half_reg;
                if (rx_full_reg && rx_half_reg)
                    rx_full_reg <= 1'b0;
            end
        end
    end

    // ========================================================
    // Collision and carrier sense
    // ========================================================
    // Line events qualified by activity.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nib_col <= 1'b0;
            nib_crs <= 1'b0;
        end
        else
        begin
            nib_col <= line_collision && tx_active_reg;
            nib_crs <= tx_active_reg || line_rx_active;
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    sequence s_an_idle;
        an_on && !partner_ability_new;
    endsequence

    a_speed_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0({set_1000, set_100, set_10}))
        else $error("more than one speed output");
    a_basex_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && !sgmii |=> set_1000 && !set_100 && !set_10 &&
        !half_duplex_active)
        else $error("1000BASE-X status wrong");
    a_an_gig_speed: assert property (@(posedge pclk) disable iff (!presetn)
        an_on && ability_reg[PCSC_AB_LINK] && ab_spd == PCSC_SPD_1000
        |=> set_1000) else $error("gigabit ability ignored");
    a_an_100_speed: assert property (@(posedge pclk) disable iff (!presetn)
        an_on && ability_reg[PCSC_AB_LINK] && ab_spd == PCSC_SPD_100
        |=> set_100) else $error("100 ability ignored");
    a_an_10_speed: assert property (@(posedge pclk) disable iff (!presetn)
        an_on && ability_reg[PCSC_AB_LINK] && ab_spd == PCSC_SPD_10
        |=> set_10) else $error("10 ability ignored");
    a_manual_speed: assert property (@(posedge pclk) disable iff (!presetn)
        sgmii && !an_on |=> set_1000 == $past(man_spd == PCSC_SPD_1000) &&
        set_10 == $past(man_spd == PCSC_SPD_10))
        else $error("manual speed not followed");
    a_manual_duplex: assert property (@(posedge pclk) disable iff (!presetn)
        sgmii && !an_on |=>
        half_duplex_active == $past(ctrl_reg[PCSC_CTRL_DUPLEX]))
        else $error("manual duplex not followed");
    a_an_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s_an_idle ##1 s_an_idle |=> $stable({set_1000, set_100, set_10}))
        else $error("status moved without new ability");
    a_rx_err_framed: assert property (@(posedge pclk) disable iff (!presetn)
        (gig_rx_err |-> gig_rx_valid) and (nib_rx_err |-> nib_rx_valid))
        else $error("receive error outside frame");
    a_rx_valid_tick: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(gig_rx_valid) |-> $past(tick))
        else $error("receive valid moved off tick");
    a_col_on_tx: assert property (@(posedge pclk) disable iff (!presetn)
        nib_col |-> $past(line_collision && tx_active_reg))
        else $error("collision without transmit");
    a_crs_activity: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_active_reg || line_rx_active) |=> nib_crs)
        else $error("carrier sense missed");
    a_no_ena_basex: assert property (@(posedge pclk) disable iff (!presetn)
        !sgmii |-> !tx_clk_ena && !rx_clk_ena)
        else $error("enable driven in 1000BASE-X");

endmodule // pcsc_client_port
`default_nettype wire

// file: hdl/pcsc_clken_gen.sv
// Clock enable divider: one-cycle ticks at the selected client rate, or every cycle when the rate is off.
// Assumes rate changes are rare; the count restarts on each change.
`timescale 1ns/100ps
`default_nettype none
module pcsc_clken_gen
    import pcsc_pkg::*;
(
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Enable carrier
    pcsc_clken_if.gen   ce
);

    logic [PCSC_DIV_W-1:0] cnt_reg;
    pcsc_rate_t            rate_q_reg;

    function automatic logic [PCSC_DIV_W-1:0] last_count(pcsc_rate_t r);
        unique case (r)
            PCSC_RATE_10:  last_count = PCSC_DIV_W'(PCSC_DIV_10 - 1);
            PCSC_RATE_100: last_count = PCSC_DIV_W'(PCSC_DIV_100 - 1);
            default:       last_count = PCSC_DIV_W'(PCSC_DIV_1000 - 1);
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg    <= '0;
            rate_q_reg <= PCSC_RATE_OFF;
        end
        else
        begin
            rate_q_reg <= ce.rate;
            if (ce.rate != rate_q_reg || cnt_reg >= last_count(ce.rate))
                cnt_reg <= '0;
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign ce.tick = (cnt_reg == '0) && (ce.rate == rate_q_reg);

    // A tick at 10 Mbps is not followed by another tick 8 cycles later.
    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (ce.tick && ce.rate == PCSC_RATE_10) ##1 (ce.rate == PCSC_RATE_10)
        [*8] |-> !ce.tick) else $error("tick too soon at 10 Mbps");

endmodule // pcsc_clken_gen
`default_nettype wire

// file: hdl/pcsc_clken_if.sv
// Carrier between the client port and its clock enable generator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface pcsc_clken_if;
    import pcsc_pkg::*;
    pcsc_rate_t rate;
    logic       tick;
    modport gen  (input rate, output tick);
    modport user (output rate, input tick);
endinterface
`default_nettype wire

// file: hdl/pcsc_pkg.sv
// Shared constants for the PCS client port: register map, fields, rates.
// Assumes a 32-bit APB register bus and one 40 MHz clock.
package pcsc_pkg;

    // ========================================================
    // Rates and clock enable division
    // ========================================================
    typedef enum logic [1:0] {
        PCSC_RATE_10,
        PCSC_RATE_100,
        PCSC_RATE_1000,
        PCSC_RATE_OFF
    } pcsc_rate_t;

    localparam int unsigned PCSC_DIV_1000 = 1;
    localparam int unsigned PCSC_DIV_100  = 10;
    localparam int unsigned PCSC_DIV_10   = 100;
    localparam int unsigned PCSC_DIV_W    = 7;

    // ========================================================
    // Register map
    // ========================================================
    localparam logic [11:0] PCSC_ADDR_CTRL    = 12'h000;
    localparam logic [11:0] PCSC_ADDR_STATUS  = 12'h004;
    localparam logic [11:0] PCSC_ADDR_ABILITY = 12'h008;

    localparam int unsigned PCSC_CTRL_SGMII   = 0;
    localparam int unsigned PCSC_CTRL_AN      = 1;
    localparam int unsigned PCSC_CTRL_SPD_LSB = 2;
    localparam int unsigned PCSC_CTRL_DUPLEX  = 4;
    localparam int unsigned PCSC_CTRL_W       = 5;
    localparam logic [4:0]  PCSC_CTRL_RESET   = 5'h00;

    // Manual speed field codes.
    localparam logic [1:0]  PCSC_SPD_1000 = 2'h2;
    localparam logic [1:0]  PCSC_SPD_100  = 2'h1;
    localparam logic [1:0]  PCSC_SPD_10   = 2'h0;

    // ========================================================
    // Partner ability word layout
    // ========================================================
    localparam int unsigned PCSC_AB_W       = 16;
    localparam int unsigned PCSC_AB_LINK    = 15;
    localparam int unsigned PCSC_AB_DUPLEX  = 12;
    localparam int unsigned PCSC_AB_SPD_LSB = 10;
    localparam logic [15:0] PCSC_AB_RESET   = 16'h0000;

endpackage

// file: tb/pcs_gmii_mii_client_port_test.sv
// Testbench of the client port: status, clock enables, transmit, receive.
// Assumes the MAC model is compiled first; the line side is driven here.
`timescale 1ns/100ps
`default_nettype none
module pcs_gmii_mii_client_port_test;
    import pcsc_pkg::*;
    localparam logic [7:0] FIRST = 8'h5A;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, sg = 1'b0, mac_nib = 1'b0, mac_go = 1'b0;
    logic [7:0]  gig_tx_data, gig_rx_data, line_tx_data;
    logic [7:0]  line_rx_data = 8'h00;
    logic [3:0]  nib_tx_data, nib_rx_data;
    logic        gig_tx_en, gig_tx_err, nib_tx_en, nib_tx_err;
    logic        gig_rx_valid, gig_rx_err, nib_rx_valid, nib_rx_err;
    logic        nib_col, nib_crs, set_1000, set_100, set_10;
    logic        half_duplex_active, tx_clk_ena, rx_clk_ena;
    logic        line_tx_valid, line_tx_err, line_rx_ready;
    logic        line_rx_valid = 1'b0, line_rx_err = 1'b0;
    logic        line_rx_active = 1'b0, line_collision = 1'b0;
    logic [15:0] partner_ability = 16'h0000;
    logic        partner_ability_new = 1'b0;
    int          num_errors = 0, n_compared = 0;
    wire         mac_ce = sg ? tx_clk_ena : 1'b1;

    pcsc_client_port i_pcsc_client_port (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .gig_tx_data, .gig_tx_en,
        .gig_tx_err, .nib_tx_data, .nib_tx_en, .nib_tx_err,
        .gig_rx_data, .gig_rx_valid, .gig_rx_err, .nib_rx_data,
        .nib_rx_valid, .nib_rx_err, .nib_col, .nib_crs, .set_1000,
        .set_100, .set_10, .half_duplex_active, .tx_clk_ena,
        .rx_clk_ena, .line_tx_data, .line_tx_valid, .line_tx_err,
        .line_rx_data, .line_rx_valid, .line_rx_err, .line_rx_ready,
        .line_rx_active, .line_collision, .partner_ability,
        .partner_ability_new
    );
    pcsc_mac_model i_pcsc_mac_model (
        .pclk, .presetn, .ce(mac_ce), .nib(mac_nib), .go(mac_go),
        .first(FIRST), .gig_tx_data, .gig_tx_en, .gig_tx_err,
        .nib_tx_data, .nib_tx_en, .nib_tx_err
    );

    always #12.5 pclk = ~pclk;

    // ====================================================
    // Shared tasks
    // ====================================================
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Read data is only compared on reads; the error flag always.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, erd, input logic eer);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w)
            chk("prdata", erd, prdata);
        chk("pslverr", eer, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic mode(input logic [31:0] c);
        apb(1'b1, PCSC_ADDR_CTRL, c, 32'h0, 1'b0);
        sg <= c[0];
        cyc(3);
    endtask

    task automatic spd(input logic [3:0] e);
        @(negedge pclk);
        chk("status", e, {half_duplex_active, set_10, set_100, set_1000});
    endtask

    task automatic ticks(input int n, input logic [31:0] e);
        int t;
        t = 0;
        repeat (n)
        begin
            @(negedge pclk);
            t += (tx_clk_ena === 1'b1) + (rx_clk_ena === 1'b1);
        end
        chk("ticks", e, t);
    endtask

    task automatic ability(input logic [15:0] v);
        @(posedge pclk);
        partner_ability <= v;
        partner_ability_new <= 1'b1;
        @(posedge pclk);
        partner_ability_new <= 1'b0;
        cyc(2);
    endtask

    task automatic line_byte(input logic [7:0] d, input logic e);
        @(posedge pclk);
        line_rx_valid <= 1'b1;
        line_rx_data <= d;
        line_rx_err <= e;
        do @(posedge pclk); while (line_rx_ready !== 1'b1);
        line_rx_valid <= 1'b0;
        line_rx_data <= ~d;
        line_rx_err <= 1'b0;
    endtask

    // ====================================================
    // Scenarios
    // ====================================================
    task automatic t_reset;
        cyc(1);
        spd(4'b0001);
        ticks(20, 0);
        apb(1'b0, PCSC_ADDR_STATUS, 0, 32'h1, 1'b0);
        apb(1'b1, PCSC_ADDR_STATUS, 32'hF, 0, 1'b1);
        apb(1'b0, 12'h00C, 0, 32'h0, 1'b1);
        apb(1'b0, PCSC_ADDR_CTRL, 0, 32'h0, 1'b0);
    endtask

    task automatic t_manual;
        int d;
        for (int c = 2; c >= 0; c--)
        begin
            d = c == 2 ? PCSC_DIV_1000 : c == 1 ? PCSC_DIV_100 : PCSC_DIV_10;
            mode(1 | c << 2 | (c == 1) << 4);
            apb(1'b0, PCSC_ADDR_CTRL, 0, 1 | c << 2 | (c == 1) << 4, 1'b0);
            spd({c == 1, 3'b001 << (2 - c)});
            ticks(200, 400 / d);
        end
    endtask

    task automatic t_autoneg;
        mode(3);
        for (int c = 2; c >= 0; c--)
        begin
            ability(16'h8000 | c << 10 | (c == 2) << 12);
            spd({c != 2, 3'b001 << (2 - c)});
        end
        @(posedge pclk);
        partner_ability <= 16'h9800;
        cyc(4);
        spd(4'b1100);
        apb(1'b0, PCSC_ADDR_ABILITY, 0, 32'h8000, 1'b0);
        ability(16'h1800);
        spd(4'b0000);
    endtask

    task automatic tx_frame(input logic nb);
        int k;
        k = 0;
        mac_nib <= nb;
        mac_go <= 1'b1;
        for (int i = 0; i < 400 && k < 4; i++)
        begin
            @(negedge pclk);
            if (line_tx_valid === 1'b1)
            begin
                chk("line_tx_data", FIRST + k, line_tx_data);
                chk("line_tx_err", k == 1, line_tx_err);
                k++;
            end
        end
        chk("tx_bytes", 4, k);
        @(posedge pclk);
        mac_go <= 1'b0;
        cyc(30);
    endtask

    task automatic rx_frame(input logic nb);
        int k;
        logic tk, st;
        k = 0;
        tk = 1'b0;
        st = 1'b0;
        fork
            for (int j = 0; j < 4; j++)
                line_byte(FIRST + j, j == 2);
            for (int i = 0; i < 900 && k < (nb ? 8 : 4); i++)
            begin
                @(negedge pclk);
                st = st || (nb && nib_rx_valid === 1'b1);
                if (st)
                    chk("nib_rx_valid", 1, nib_rx_valid);
                if (st && tk)
                begin
                    chk("nib_rx_data", ((FIRST + k / 2) >> (k % 2 * 4)) & 15,
                        nib_rx_data);
                    chk("nib_rx_err", k / 2 == 2, nib_rx_err);
                    k++;
                end
                if (!nb && gig_rx_valid === 1'b1)
                begin
                    chk("gig_rx_data", FIRST + k, gig_rx_data);
                    chk("gig_rx_err", k == 2, gig_rx_err);
                    k++;
                end
                tk = rx_clk_ena;
            end
        join
        chk("rx_units", nb ? 8 : 4, k);
    endtask

    task automatic t_col;
        @(posedge pclk);
        mac_nib <= 1'b1;
        mac_go <= 1'b1;
        cyc(30);
        line_collision <= 1'b1;
        cyc(2);
        @(negedge pclk);
        chk("nib_col", 1, nib_col);
        chk("nib_crs", 1, nib_crs);
        @(posedge pclk);
        mac_go <= 1'b0;
        cyc(40);
        @(negedge pclk);
        chk("nib_col", 0, nib_col);
        chk("nib_crs", 0, nib_crs);
        @(posedge pclk);
        line_rx_active <= 1'b1;
        cyc(2);
        @(negedge pclk);
        chk("nib_crs", 1, nib_crs);
    endtask

    // ====================================================
    // Main sequence and watchdog
    // ====================================================
    initial
    begin
        cyc(16);
        presetn <= 1'b1;
        t_reset;
        t_manual;
        t_autoneg;
        mode(0);
        tx_frame(1'b0);
        rx_frame(1'b0);
        mode(5);
        tx_frame(1'b1);
        rx_frame(1'b1);
        t_col;
        final_report;
    end

    initial
    begin
        #(25 * 30000);
        num_errors++;
        final_report;
    end
endmodule // pcs_gmii_mii_client_port_test
`default_nettype wire

// file: tb/pcsc_mac_model.sv
// MAC transmit model: streams a counting frame into the client port.
// Assumes ce marks the client cycles and go frames the burst.
`timescale 1ns/100ps
`default_nettype none
module pcsc_mac_model
(
    // Clock, reset and control
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       nib,
    input  wire logic       go,
    input  wire logic [7:0] first,
    // MAC transmit
    output logic [7:0]      gig_tx_data,
    output logic            gig_tx_en,
    output logic            gig_tx_err,
    output logic [3:0]      nib_tx_data,
    output logic            nib_tx_en,
    output logic            nib_tx_err
);
    logic [7:0] cnt_reg;
    logic       hi_reg;
    logic       bad;

    // ====================================================
    // Frame stream
    // ====================================================
    // one errored byte.
    assign bad = (cnt_reg == first + 8'h01);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 8'h00;
            hi_reg <= 1'b0;
            gig_tx_data <= 8'h00;
            nib_tx_data <= 4'h0;
            {gig_tx_en, gig_tx_err, nib_tx_en, nib_tx_err} <= 4'h0;
        end
        else if (!go)
        begin
            // Idle data toggles, so a stale byte never looks valid.
            cnt_reg <= first;
            hi_reg <= 1'b0;
            gig_tx_data <= ~gig_tx_data;
            nib_tx_data <= ~nib_tx_data;
            {gig_tx_en, gig_tx_err, nib_tx_en, nib_tx_err} <= 4'h0;
        end
        else if (ce)
        begin
            gig_tx_en <= !nib;
            gig_tx_err <= !nib && bad;
            gig_tx_data <= cnt_reg;
            nib_tx_en <= nib;
            nib_tx_err <= nib && bad;
            nib_tx_data <= hi_reg ? cnt_reg[7:4] : cnt_reg[3:0];
            hi_reg <= nib && !hi_reg;
            if (!nib || hi_reg)
                cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // pcsc_mac_model
`default_nettype wire
